// ### inc/rac_pkg.sv
package rac_pkg;

	// Frame opening commands, both sent as seven-bit short frames.
	localparam logic [7:0] CMD_REQA         = 8'h26;
	localparam logic [7:0] CMD_WUPA         = 8'h52;
	localparam logic [2:0] SHORT_FRAME_BITS = 3'h7;

	// Select codes per cascade level and the second byte of a select frame.
	localparam logic [7:0] SEL_LEVEL_ONE    = 8'h93;
	localparam logic [7:0] SEL_LEVEL_TWO    = 8'h95;
	localparam logic [7:0] SEL_LEVEL_THREE  = 8'h97;
	localparam logic [7:0] NVB_SELECT       = 8'h70;
	localparam logic [7:0] CASCADE_TAG      = 8'h88;

	// Bit positions inside the card answers.
	localparam logic [2:0] ATQA_SIZE_LSB    = 3'h6;
	localparam logic [2:0] SAK_CASCADE_BIT  = 3'h2;

	// Identifier size codes and cascade level numbers.
	localparam logic [1:0] SIZE_SINGLE      = 2'h0;
	localparam logic [1:0] SIZE_DOUBLE      = 2'h1;
	localparam logic [1:0] SIZE_TRIPLE      = 2'h2;
	localparam logic [1:0] LEVEL_NONE       = 2'h0;
	localparam logic [1:0] LEVEL_ONE        = 2'h1;
	localparam logic [1:0] LEVEL_TWO        = 2'h2;
	localparam logic [1:0] LEVEL_THREE      = 2'h3;

	// Frame layout: command and NVB head, identifier bits, select length.
	localparam logic [3:0] HEAD_BYTES       = 4'h2;
	localparam logic [5:0] ID_BITS          = 6'h20;
	localparam logic [2:0] SELECT_LAST_IDX  = 3'h6;
	localparam logic [2:0] CHECK_BYTE_IDX   = 3'h4;

	// Transmit word: {crc, last, valid bits of byte (0 = all 8), data}.
	localparam int TX_WORD_W = 13;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_REQ   = 7'h02,
		ST_ATQA  = 7'h04,
		ST_ACTX  = 7'h08,
		ST_UIDRX = 7'h10,
		ST_SELTX = 7'h20,
		ST_SAKRX = 7'h40
	} rac_state_type;

endpackage : rac_pkg

// ### verilog/rac_skid_buffer.sv
`timescale 1ns/1ns

// Two-entry buffer; both outputs come from flip-flops so nothing is lost on a stall.
module rac_skid_buffer #(
	parameter int WIDTH = 13
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             reset_n,
	// Filling side.
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Draining side.
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);

	logic             out_valid_r, out_valid_nxt;
	logic [WIDTH-1:0] out_data_r,  out_data_nxt;
	logic             skid_valid_r, skid_valid_nxt;
	logic [WIDTH-1:0] skid_data_r, skid_data_nxt;

	// The skid slot absorbs the word accepted in the cycle the receiver stalls.
	always_comb begin
		out_valid_nxt  = out_valid_r;
		out_data_nxt   = out_data_r;
		skid_valid_nxt = skid_valid_r;
		skid_data_nxt  = skid_data_r;
		if (out_ready || !out_valid_r) begin
			if (skid_valid_r) begin
				out_valid_nxt  = 1'b1;
				out_data_nxt   = skid_data_r;
				skid_valid_nxt = 1'b0;
			end else begin
				out_valid_nxt = in_valid;
				out_data_nxt  = in_data;
			end
		end else if (in_valid && !skid_valid_r) begin
			skid_valid_nxt = 1'b1;
			skid_data_nxt  = in_data;
		end
	end

	// Registers only.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			out_valid_r  <= 1'b0;
			out_data_r   <= '0;
			skid_valid_r <= 1'b0;
			skid_data_r  <= '0;
		end else begin
			out_valid_r  <= out_valid_nxt;
			out_data_r   <= out_data_nxt;
			skid_valid_r <= skid_valid_nxt;
			skid_data_r  <= skid_data_nxt;
		end
	end

	assign in_ready  = !skid_valid_r;
	assign out_valid = out_valid_r;
	assign out_data  = out_data_r;

endmodule : rac_skid_buffer

// ### verilog/rac_anticoll.sv
`timescale 1ns/1ns

// Functional notes
// - Open with a REQA or WUPA short frame, then wait for ATQA.
// - ATQA bits b8 b7: 00 single, 10 triple; set level count from it.
// - ATQA bits b8 b7 equal 01 mean double size, two levels.
// - A collided ATQA still leads into the anticollision loop.
// - After ATQA send level one anticollision 93h 20h.
// - Level one select: 93h 70h, five received bytes, CRC_A.
// - SAK b3 set after level one: go to level two, send 95h 20h; here only if ATQA gave double or triple size, else it ends failed.
// - Level two select: 95h 70h, five received bytes, CRC_A.
// - SAK b3 set after level two: go to level three, send 97h 20h; here only if ATQA gave triple size, else it ends failed.
// - Level three select: 97h 70h, four id bytes, check byte, CRC_A.
// - SAK b3 clear: identifier complete, stop raising the level.
// - While colliding, send code, NVB, first k bits for k 1 to 31.
// - Each step resends k-1 known bits plus one chosen bit.
// - Optional 93h 60h with all 32 bits; card returns check byte only.
// - Select with 32 bits and check byte, computed if 60h skipped.
module rac_anticoll
	import rac_pkg::*;
(
	// Clock and reset.
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	// User control.
	input  wire logic                 start,
	input  wire logic                 use_wakeup,
	input  wire logic                 send_full_id,
	input  wire logic                 chosen_bit,
	// User status.
	output logic                      busy,
	output logic                      done,
	output logic                      failed,
	output logic [1:0]                cascade_level,
	output logic [7:0]                sak_byte,
	output logic [31:0]               level_id,
	// Transmit stream toward the RF framer.
	output logic                      tx_valid,
	output logic [7:0]                tx_data,
	output logic [2:0]                tx_bits,
	output logic                      tx_last,
	output logic                      tx_crc,
	input  wire logic                 tx_ready,
	// Receive stream from the RF framer.
	input  wire logic                 rx_valid,
	input  wire logic [7:0]           rx_data,
	input  wire logic [7:0]           rx_coll,
	input  wire logic                 rx_last
);

	rac_state_type          st_r, st_nxt;
	logic [1:0]             lvl_r, lvl_nxt, levels_r, levels_nxt;
	logic [5:0]             k_r, k_nxt;
	logic [39:0]            uid_r, uid_nxt;
	logic [2:0]             txi_r, txi_nxt, rxi_r, rxi_nxt;
	logic                   coll_r, coll_nxt, wake_r, wake_nxt;
	logic                   busy_r, busy_nxt, done_r, done_nxt, fail_r, fail_nxt;
	logic [7:0]             sak_r, sak_nxt;
	logic [31:0]            id_r, id_nxt;
	logic                   push, buf_ready;
	logic [TX_WORD_W-1:0]   push_word, buf_word;
	logic [7:0]             cmd, nvb, mask;
	logic [2:0]             ac_last, pos;
	logic                   coll_any;

	// Check byte over four identifier bytes.
	function automatic logic [7:0] check_of(input logic [39:0] u);
		check_of = u[7:0] ^ u[15:8] ^ u[23:16] ^ u[31:24];
	endfunction : check_of

	// Level count from the ATQA size field; the reserved code gives none.
	function automatic logic [1:0] levels_of(input logic [1:0] size);
		case (size)
			SIZE_SINGLE: levels_of = LEVEL_ONE;
			SIZE_DOUBLE: levels_of = LEVEL_TWO;
			SIZE_TRIPLE: levels_of = LEVEL_THREE;
			default:     levels_of = LEVEL_NONE;
		endcase
	endfunction : levels_of

	// Select code, NVB and the index of the last anticollision byte.
	always_comb begin
		case (lvl_r)
			LEVEL_TWO:   cmd = SEL_LEVEL_TWO;
			LEVEL_THREE: cmd = SEL_LEVEL_THREE;
			default:     cmd = SEL_LEVEL_ONE;
		endcase
		nvb     = {4'(HEAD_BYTES + {1'b0, k_r[5:3]}), 1'b0, k_r[2:0]};
		ac_last = 3'(3'h1 + k_r[5:3] + {2'h0, (k_r[2:0] != 3'h0)});
		pos     = 3'(k_r[5:3] + rxi_r);
		mask    = (pos == k_r[5:3]) ? 8'((8'h01 << k_r[2:0]) - 8'h01) : 8'h00;
		coll_any = coll_r || (rx_coll != 8'h00);
	end

	// Sequencer: request, anticollision per level, select, SAK evaluation.
	always_comb begin
		st_nxt = st_r;     lvl_nxt = lvl_r;   levels_nxt = levels_r;
		k_nxt = k_r;       uid_nxt = uid_r;   txi_nxt = txi_r;
		rxi_nxt = rxi_r;   coll_nxt = coll_r; wake_nxt = wake_r;
		busy_nxt = busy_r; done_nxt = 1'b0;   fail_nxt = fail_r;
		sak_nxt = sak_r;   id_nxt = id_r;
		push = 1'b0;
		push_word = '0;
		unique case (st_r)
			ST_IDLE: if (start) begin
				st_nxt = ST_REQ;
				lvl_nxt = LEVEL_ONE;
				k_nxt = 6'h00;
				uid_nxt = '0;
				wake_nxt = use_wakeup;
				busy_nxt = 1'b1;
				fail_nxt = 1'b0;
			end
			ST_REQ: begin
				push = 1'b1;
				push_word = {1'b0, 1'b1, SHORT_FRAME_BITS, wake_r ? CMD_WUPA : CMD_REQA};
				if (buf_ready) begin
					st_nxt = ST_ATQA;
					rxi_nxt = 3'h0;
				end
			end
			ST_ATQA: if (rx_valid) begin
				rxi_nxt = 3'(rxi_r + 3'h1);
				if (rxi_r == 3'h0)
					levels_nxt = levels_of(rx_data[ATQA_SIZE_LSB +: 2]);
				// Collisions in the answer are ignored on purpose.
				if (rx_last) begin
					txi_nxt = 3'h0;
					st_nxt = (levels_nxt == LEVEL_NONE) ? ST_IDLE : ST_ACTX;
					if (levels_nxt == LEVEL_NONE) begin
						busy_nxt = 1'b0;
						done_nxt = 1'b1;
						fail_nxt = 1'b1;
					end
				end
			end
			ST_ACTX: begin
				push = 1'b1;
				push_word[12]  = 1'b0;
				push_word[11]  = (txi_r == ac_last);
				push_word[10:8] = (txi_r == ac_last && txi_r > 3'h1) ? k_r[2:0] : 3'h0;
				push_word[7:0] = (txi_r == 3'h0) ? cmd : (txi_r == 3'h1) ? nvb :
					uid_r[8*(3'(txi_r - 3'h2)) +: 8];
				if (buf_ready) begin
					txi_nxt = 3'(txi_r + 3'h1);
					if (txi_r == ac_last) begin
						st_nxt = ST_UIDRX;
						rxi_nxt = 3'h0;
						coll_nxt = 1'b0;
					end
				end
			end
			ST_UIDRX: if (rx_valid) begin
				if (pos <= CHECK_BYTE_IDX)
					uid_nxt[8*pos +: 8] = (uid_r[8*pos +: 8] & mask) | (rx_data & ~mask);
				rxi_nxt = 3'(rxi_r + 3'h1);
				coll_nxt = coll_any;
				if (rx_last) begin
					txi_nxt = 3'h0;
					if (coll_any && k_r < ID_BITS) begin
						uid_nxt[k_r] = chosen_bit;
						k_nxt = 6'(k_r + 6'h01);
						st_nxt = ST_ACTX;
						if (k_nxt == ID_BITS && !send_full_id) begin
							uid_nxt[39:32] = check_of(uid_nxt);
							st_nxt = ST_SELTX;
						end
					end else if (coll_any || check_of(uid_nxt) != uid_nxt[39:32] ||
						(lvl_r < levels_r && uid_nxt[7:0] != CASCADE_TAG)) begin
						st_nxt = ST_IDLE;
						busy_nxt = 1'b0;
						done_nxt = 1'b1;
						fail_nxt = 1'b1;
					end else begin
						k_nxt = ID_BITS;
						st_nxt = ST_SELTX;
					end
				end
			end
			ST_SELTX: begin
				push = 1'b1;
				push_word[12]  = (txi_r == SELECT_LAST_IDX);
				push_word[11]  = (txi_r == SELECT_LAST_IDX);
				push_word[10:8] = 3'h0;
				push_word[7:0] = (txi_r == 3'h0) ? cmd : (txi_r == 3'h1) ? NVB_SELECT :
					uid_r[8*(3'(txi_r - 3'h2)) +: 8];
				if (buf_ready) begin
					txi_nxt = 3'(txi_r + 3'h1);
					if (txi_r == SELECT_LAST_IDX)
						st_nxt = ST_SAKRX;
				end
			end
			ST_SAKRX: if (rx_valid) begin
				sak_nxt = rx_data;
				id_nxt = uid_r[31:0];
				txi_nxt = 3'h0;
				if (rx_data[SAK_CASCADE_BIT] && lvl_r < levels_r) begin
					lvl_nxt = 2'(lvl_r + 2'h1);
					k_nxt = 6'h00;
					uid_nxt = '0;
					st_nxt = ST_ACTX;
				end else begin
					st_nxt = ST_IDLE;
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
					fail_nxt = rx_data[SAK_CASCADE_BIT];
				end
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ST_IDLE;    lvl_r <= LEVEL_NONE; levels_r <= LEVEL_NONE;
			k_r <= 6'h00;       uid_r <= '0;         txi_r <= 3'h0;
			rxi_r <= 3'h0;      coll_r <= 1'b0;      wake_r <= 1'b0;
			busy_r <= 1'b0;     done_r <= 1'b0;      fail_r <= 1'b0;
			sak_r <= 8'h00;     id_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;     lvl_r <= lvl_nxt;    levels_r <= levels_nxt;
			k_r <= k_nxt;       uid_r <= uid_nxt;    txi_r <= txi_nxt;
			rxi_r <= rxi_nxt;   coll_r <= coll_nxt;  wake_r <= wake_nxt;
			busy_r <= busy_nxt; done_r <= done_nxt;  fail_r <= fail_nxt;
			sak_r <= sak_nxt;   id_r <= id_nxt;
		end
	end

	// The buffer lets the framer stall without the sequencer losing a byte.
	rac_skid_buffer #(.WIDTH(TX_WORD_W)) u_txbuf (
		.clock     (clock),
		.reset_n   (reset_n),
		.in_valid  (push),
		.in_data   (push_word),
		.in_ready  (buf_ready),
		.out_valid (tx_valid),
		.out_data  (buf_word),
		.out_ready (tx_ready)
	);

	assign {tx_crc, tx_last, tx_bits, tx_data} = buf_word;
	assign busy = busy_r;
	assign done = done_r;
	assign failed = fail_r;
	assign cascade_level = lvl_r;
	assign sak_byte = sak_r;
	assign level_id = id_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence sak_final_s;
		st_r == ST_SAKRX && rx_valid && !rx_data[SAK_CASCADE_BIT];
	endsequence
	sequence finish_s;
		done_r && !busy_r && st_r == ST_IDLE;
	endsequence

	req_frame_a: assert property (push && st_r == ST_REQ |->
		push_word[10:8] == 3'h7 && (push_word[7:0] == 8'h26 || push_word[7:0] == 8'h52))
		else $error("opening frame is not a short REQA or WUPA");
	size_single_a: assert property (st_r == ST_ATQA && rx_valid && rxi_r == 3'h0 &&
		rx_data[7:6] == 2'h0 |=> levels_r == 2'h1) else $error("single size not one level");
	size_triple_a: assert property (st_r == ST_ATQA && rx_valid && rxi_r == 3'h0 &&
		rx_data[7:6] == 2'h2 |=> levels_r == 2'h3) else $error("triple size not three levels");
	size_double_a: assert property (st_r == ST_ATQA && rx_valid && rxi_r == 3'h0 &&
		rx_data[7:6] == 2'h1 |=> levels_r == 2'h2) else $error("double size not two levels");
	atqa_coll_a: assert property (st_r == ST_ATQA && rx_valid && rx_last &&
		rxi_r != 3'h0 && levels_r != 2'h0 |=> st_r == ST_ACTX && txi_r == 3'h0)
		else $error("ATQA did not start the loop");
	first_cmd_a: assert property (st_r == ST_ACTX && push && k_r == 6'h00 && txi_r == 3'h1
		|-> push_word[7:0] == 8'h20 && push_word[11]) else $error("bad 20h anticollision byte");
	select_head_a: assert property (st_r == ST_SELTX && push && txi_r == 3'h1
		|-> push_word[7:0] == 8'h70) else $error("select frame lacks 70h");
	cascade_step_a: assert property (st_r == ST_SAKRX && rx_valid && rx_data[2] &&
		lvl_r < levels_r |=> st_r == ST_ACTX && lvl_r == $past(lvl_r) + 2'h1 && k_r == 6'h00)
		else $error("cascade bit did not raise the level");
	sak_done_a: assert property (sak_final_s |=> finish_s ##1 !done_r)
		else $error("complete SAK did not end the loop");
	bit_step_a: assert property (st_r == ST_UIDRX && rx_valid && rx_last && coll_any &&
		k_r < 6'h20 |=> k_r == $past(k_r) + 6'h01 && uid_r[$past(k_r)] == $past(chosen_bit))
		else $error("collision did not add one chosen bit");
	nvb_form_a: assert property (st_r == ST_ACTX && push && txi_r == 3'h1
		|-> push_word[7:4] == 4'h2 + k_r[5:3] && push_word[3:0] == {1'b0, k_r[2:0]})
		else $error("NVB does not match known bits");

endmodule : rac_anticoll

// ### testbench/rac_card_model.sv
`timescale 1ns/1ns

// Card stand-in: gathers each reader frame, then answers it one byte a cycle.
module rac_card_model
	import rac_pkg::*;
(
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Scenario setup.
	input  wire logic [1:0]  size_code,
	input  wire logic        full_coll,
	input  wire logic [79:0] uid,
	input  wire logic        stall,
	// Frames from the reader.
	input  wire logic        tx_valid,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_last,
	output logic             tx_ready,
	// Answers to the reader.
	output logic             rx_valid,
	output logic [7:0]       rx_data,
	output logic [7:0]       rx_coll,
	output logic             rx_last
);
	logic [7:0]  frm [0:7];
	logic [15:0] ans [$];
	int          n;

	// The framer stalls whenever the bench asks, so the buffer is really exercised.
	assign tx_ready = !stall;

	// Queue one answer byte together with its collision flags.
	task automatic put(input logic [7:0] d, input logic [7:0] c);
		ans.push_back({d, c});
	endtask : put

	// Work out the answer to one complete frame.
	task automatic respond();
		int         l;
		int         k;
		logic [7:0] b [0:3];
		l = int'(frm[0] - SEL_LEVEL_ONE) / 2;
		k = (int'(frm[1][7:4]) - 2) * 8 + int'(frm[1][3:0]);
		for (int i = 0; i < 4; i++) begin
			b[i] = (l < size_code && i == 0) ? CASCADE_TAG :
				uid[8 * (3 * l + i - ((l < size_code) ? 1 : 0)) +: 8];
		end
		if (n == 1) begin
			put({size_code, 6'h01}, 8'h00);
			put(8'h00, {7'h00, full_coll});
		end else if (frm[1] == NVB_SELECT) begin
			put({5'h00, l < size_code, 2'h0}, 8'h00);
		end else if (frm[1] == 8'h60) begin
			put(frm[2] ^ frm[3] ^ frm[4] ^ frm[5], 8'h00);
		end else if (full_coll) begin
			for (int i = k / 8; i < 5; i++) begin
				put(8'h00, (i == k / 8) ? 8'hFF << (k % 8) : 8'hFF);
			end
		end else begin
			for (int i = 0; i < 4; i++) put(b[i], 8'h00);
			put(b[0] ^ b[1] ^ b[2] ^ b[3], 8'h00);
		end
	endtask : respond

	// Released data and collision lines toggle, so a stale byte is never mistaken for data.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			n = 0;
			ans.delete();
			rx_valid <= 1'b0;
			rx_last  <= 1'b0;
			rx_data  <= 8'h00;
			rx_coll  <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			rx_last  <= 1'b0;
			rx_data  <= ~rx_data;
			rx_coll  <= ~rx_coll;
			if (tx_valid && tx_ready) begin
				frm[n[2:0]] = tx_data;
				n = n + 1;
				if (tx_last) begin
					respond();
					n = 0;
				end
			end else if (ans.size() > 0) begin
				rx_valid           <= 1'b1;
				{rx_data, rx_coll} <= ans.pop_front();
				rx_last            <= ans.size() == 0;
			end
		end
	end

endmodule : rac_card_model

// ### testbench/tb.sv
`timescale 1ns/1ns

module tb;
	import rac_pkg::*;

	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        start = 1'b0;
	logic        use_wakeup = 1'b0;
	logic        send_full_id = 1'b0;
	logic        chosen_bit = 1'b0;
	logic        busy, done, failed, tx_valid, tx_ready, tx_last, tx_crc, rx_valid, rx_last;
	logic [1:0]  cascade_level;
	logic [7:0]  sak_byte, tx_data, rx_data, rx_coll, fb;
	logic [2:0]  tx_bits;
	logic [31:0] level_id;
	logic [1:0]  size_code = 2'h0;
	logic        full_coll = 1'b0;
	logic [79:0] uid;
	logic        stall = 1'b0;
	int          heavy = 1;
	int          seed = 90438;
	int          error_cnt = 0;
	int          checked = 0;
	logic [12:0] exp_q [$];

	rac_anticoll dut (.clock(clock), .reset_n(reset_n), .start(start), .use_wakeup(use_wakeup),
		.send_full_id(send_full_id), .chosen_bit(chosen_bit), .busy(busy), .done(done),
		.failed(failed), .cascade_level(cascade_level), .sak_byte(sak_byte), .level_id(level_id),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_bits(tx_bits), .tx_last(tx_last),
		.tx_crc(tx_crc), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_coll(rx_coll), .rx_last(rx_last));

	rac_card_model card (.clock(clock), .reset_n(reset_n), .size_code(size_code),
		.full_coll(full_coll), .uid(uid), .stall(stall), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_coll(rx_coll), .rx_last(rx_last));

	// Free-running 100 MHz clock.
	always #5 clock = ~clock;

	// Random framer stalls; a heavy run keeps the two-entry buffer full.
	always @(posedge clock) stall <= ($random(seed) & 3) < heavy;

	// Bits of a partial byte beyond its valid count are not compared.
	function automatic logic [7:0] msk(input logic [2:0] bits);
		return (bits == 3'h0) ? 8'hFF : 8'hFF >> (4'h8 - {1'b0, bits});
	endfunction : msk

	function automatic logic [31:0] lvl_id(input int s, input int l);
		return (l < s) ? {uid[24 * l +: 24], CASCADE_TAG} : uid[24 * l +: 32];
	endfunction : lvl_id

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic note(input logic [7:0] d, input logic [2:0] bits, input logic last,
		input logic crc);
		exp_q.push_back({d & msk(bits), bits, last, crc});
	endtask : note

	task automatic note_anti(input logic [7:0] cmd);
		note(cmd, 3'h0, 1'b0, 1'b0);
		note(8'h20, 3'h0, 1'b1, 1'b0);
	endtask : note_anti

	task automatic note_sel(input logic [7:0] cmd, input logic [31:0] id);
		note(cmd, 3'h0, 1'b0, 1'b0);
		note(NVB_SELECT, 3'h0, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) note(id[8 * i +: 8], 3'h0, 1'b0, 1'b0);
		note(id[7:0] ^ id[15:8] ^ id[23:16] ^ id[31:24], 3'h0, 1'b1, 1'b1);
	endtask : note_sel

	// Every word the framer takes is matched against the oldest noted word.
	always @(posedge clock) begin
		if (reset_n && tx_valid && tx_ready) begin
			if (exp_q.size() == 0) check(32'({tx_data, tx_bits, tx_last, tx_crc}), 32'hFFFFFFFF);
			else check(32'({tx_data & msk(tx_bits), tx_bits, tx_last, tx_crc}), 32'(exp_q.pop_front()));
		end
	end

	task automatic summarize();
		$display("Counts: checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// Start is held for two edges so the second, while busy, must be ignored.
	task automatic run(input logic wake, input logic [1:0] sz, input logic fc, input logic fid,
		input logic cb, input logic efail, input logic [1:0] elvl, input logic [31:0] eid);
		int i;
		@(posedge clock);
		size_code    <= sz;
		full_coll    <= fc;
		use_wakeup   <= wake;
		send_full_id <= fid;
		chosen_bit   <= cb;
		start        <= 1'b1;
		repeat (2) @(posedge clock);
		start <= 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 20000) begin
			@(posedge clock);
			#1;
			i++;
		end
		if (done !== 1'b1) begin
			error_cnt++;
			summarize();
		end else begin
			check(32'(failed), 32'(efail));
			check(32'(busy), 32'h0);
			if (!efail) begin
				check(32'(cascade_level), 32'(elvl));
				check(level_id, eid);
				check(32'(sak_byte), 32'h0);
			end
			repeat (3) @(posedge clock);
			check(32'(exp_q.size()), 32'h0);
			$display("Test done: size code %0d, bitwise %0d", sz, fc);
		end
	endtask : run

	initial begin
		uid = {16'($random(seed)), $random(seed), $random(seed)};
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		// Single, double and triple identifiers walk through every cascade level.
		for (int s = 0; s < 3; s++) begin
			heavy = (s == 1) ? 3 : 1;
			note((s == 1) ? CMD_WUPA : CMD_REQA, SHORT_FRAME_BITS, 1'b1, 1'b0);
			for (int l = 0; l <= s; l++) begin
				note_anti(SEL_LEVEL_ONE + 8'(2 * l));
				note_sel(SEL_LEVEL_ONE + 8'(2 * l), lvl_id(s, l));
			end
			run(s == 1, 2'(s), 1'b0, 1'b0, 1'b0, 1'b0, 2'(s + 1), lvl_id(s, s));
		end
		heavy = 2;
		// Full collision: the reader picks every bit, with and without the 60h step.
		// The first pass claims double size; its level bytes lack the 88h tag, so it fails.
		for (int f = 2; f >= 0; f--) begin
			fb = {8{1'($random(seed))}};
			note(CMD_REQA, SHORT_FRAME_BITS, 1'b1, 1'b0);
			note_anti(SEL_LEVEL_ONE);
			for (int k = 1; k < 32; k++) begin
				note(SEL_LEVEL_ONE, 3'h0, 1'b0, 1'b0);
				note({4'(2 + k / 8), 4'(k % 8)}, 3'h0, 1'b0, 1'b0);
				for (int j = 0; j <= (k - 1) / 8; j++) begin
					note(fb, (j == (k - 1) / 8) ? 3'(k % 8) : 3'h0, j == (k - 1) / 8, 1'b0);
				end
			end
			if (f != 0) begin
				note(SEL_LEVEL_ONE, 3'h0, 1'b0, 1'b0);
				note(8'h60, 3'h0, 1'b0, 1'b0);
				for (int j = 0; j < 4; j++) note(fb, 3'h0, j == 3, 1'b0);
			end
			if (f != 2) note_sel(SEL_LEVEL_ONE, {4{fb}});
			run(1'b0, 2'(f / 2), 1'b1, 1'(f != 0), fb[0], 1'(f / 2), 2'h1, {4{fb}});
		end
		// A size code of 11 ends the sequence after the ATQA.
		note(CMD_REQA, SHORT_FRAME_BITS, 1'b1, 1'b0);
		run(1'b0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 32'h0);
		summarize();
	end

endmodule : tb
